// ==== rtl/shared_bus_control.sv ====
/*
  Shared bus control register with AXI4-Lite slave, device clock selection,
  back-end power, interrupt input gating and bus width selection.
  Assumes slot type and extended width come from logic on aclk, and the
  interrupt inputs arrive asynchronously from open-drain device pins.
*/
`timescale 1ns/100ps
`include "shared_bus_defs.svh"
module shared_bus_control #(
  parameter logic [2:0] NUM_CLK_PINS = 3'h7,
  parameter logic [1:0] NUM_INT_PINS = 2'h3,
  parameter logic [6:0] BUS_WIDTH_PRESET = 7'h00,
  parameter logic [16*8*7-1:0] PRESETS = '0
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic [11:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic awvalid,
  output logic awready,
  // AXI4-Lite write data
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // AXI4-Lite write response
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read address
  input wire logic [11:0] araddr,
  input wire logic [2:0] arprot,
  input wire logic arvalid,
  output logic arready,
  // AXI4-Lite read data
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Host controller state
  input wire logic [1:0] slot_type,
  input wire logic ext_width_8,
  // Shared interrupt inputs, active low
  input wire logic [2:0] int_n,
  // Device side
  output logic [6:0] backend_power,
  output logic host_interface_supply,
  output logic [6:0] dev_clk,
  output logic [9:0] clk_divider,
  output logic [1:0] drive_strength,
  output logic clk_switching,
  output logic width_8bit,
  output logic int_pending,
  output logic use_interrupt_cycle
);

  // ****************************************************************
  // Fixed capability masks
  // ****************************************************************
  logic [6:0] dev_mask;
  logic [2:0] int_mask;
  genvar g;
  generate
    for (g = 0; g < `MAX_DEVICES; g++) begin : g_dev
      // devices up to clock pin count
      assign dev_mask[g] = (3'(g) < NUM_CLK_PINS);
    end
  endgenerate
  generate
    for (g = 0; g < 3; g++) begin : g_int
      // inputs up to interrupt pin count
      assign int_mask[g] = (2'(g) < NUM_INT_PINS);
    end
  endgenerate

  // ****************************************************************
  // State
  // ****************************************************************
  logic aw_held, next_aw_held;
  logic [11:0] aw_addr, next_aw_addr;
  logic w_held, next_w_held;
  logic [31:0] w_data, next_w_data;
  logic [3:0] w_strb, next_w_strb;
  logic next_awready, next_wready, next_arready;
  logic next_bvalid, next_rvalid;
  logic [1:0] next_bresp, next_rresp;
  logic [31:0] next_rdata;
  logic [6:0] power, next_power;
  logic [2:0] int_sel, next_int_sel;
  shared_bus_pkg::dev_sel_t clk_sel, next_clk_sel;
  logic [2:0] int_meta, int_sync;
  logic [6:0] next_backend_power;
  logic next_width_8bit, next_int_pending, next_use_interrupt_cycle;
  logic [31:0] ctrl_word;
  logic do_write;
  shared_bus_pkg::dev_sel_t eff_sel;
  logic [15:0] sel_init_preset;
  logic [11:0] ar_ofs;
  logic [1:0] ar_idx;
  int dev_base;

  clk_sel_if link ();

  // ****************************************************************
  // Register image
  // ****************************************************************
  // reserved bits zero
  assign ctrl_word = {1'b0, power, 1'b0, int_sel, 1'b0, clk_sel, 1'b0, BUS_WIDTH_PRESET & dev_mask,
                      2'h0, NUM_INT_PINS, 1'b0, NUM_CLK_PINS};
  assign eff_sel = (clk_sel > NUM_CLK_PINS) ? 3'h0 : clk_sel;
  assign dev_base = (eff_sel == 3'h0) ? 0 : (int'(eff_sel) - 1) * `PRESETS_PER_DEVICE * 16;
  assign sel_init_preset = (eff_sel == 3'h0) ? 16'h0000 : PRESETS[dev_base +: 16];
  assign ar_ofs = araddr - `PRESET_FIRST_OFS;
  assign ar_idx = ar_ofs[3:2];
  assign do_write = aw_held && w_held && !bvalid;

  // ****************************************************************
  // Address decode
  // ****************************************************************
  logic aw_is_ctrl, aw_is_preset, ar_is_ctrl, ar_is_preset;
  assign aw_is_ctrl = (aw_addr[11:2] == 10'(`CTRL_OFS >> 2));
  assign aw_is_preset = (aw_addr[11:2] >= 10'(`PRESET_FIRST_OFS >> 2)) &&
                        (aw_addr[11:2] <= 10'(`PRESET_LAST_OFS >> 2));
  assign ar_is_ctrl = (araddr[11:2] == 10'(`CTRL_OFS >> 2));
  assign ar_is_preset = (araddr[11:2] >= 10'(`PRESET_FIRST_OFS >> 2)) &&
                        (araddr[11:2] <= 10'(`PRESET_LAST_OFS >> 2));

  // ****************************************************************
  // Next values
  // ****************************************************************
  always_comb begin
    next_aw_held = aw_held;
    next_aw_addr = aw_addr;
    next_w_held = w_held;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_bvalid = bvalid;
    next_bresp = bresp;
    next_rvalid = rvalid;
    next_rdata = rdata;
    next_rresp = rresp;
    next_power = power;
    next_int_sel = int_sel;
    next_clk_sel = clk_sel;
    if (awvalid && awready) begin
      next_aw_held = 1'b1;
      next_aw_addr = awaddr;
    end
    if (wvalid && wready) begin
      next_w_held = 1'b1;
      next_w_data = wdata;
      next_w_strb = wstrb;
    end
    if (bvalid && bready) begin
      next_bvalid = 1'b0;
    end
    if (do_write) begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = `RESP_DECERR;
      if (aw_is_ctrl) begin
        next_bresp = `RESP_OKAY;
        if (w_strb[3]) begin
          next_power = w_data[`POWER_LSB +: 7];
        end
        if (w_strb[2]) begin
          next_int_sel = w_data[`INT_SEL_LSB +: 3];
          next_clk_sel = w_data[`CLK_SEL_LSB +: 3];
        end
      end else if (aw_is_preset) begin
        next_bresp = `RESP_OKAY;
      end
    end
    if (rvalid && rready) begin
      next_rvalid = 1'b0;
    end
    if (arvalid && arready) begin
      next_rvalid = 1'b1;
      next_rresp = `RESP_OKAY;
      next_rdata = 32'h0000_0000;
      if (ar_is_ctrl) begin
        next_rdata = ctrl_word;
      end else if (ar_is_preset) begin
        if (eff_sel != 3'h0) begin
          next_rdata = PRESETS[dev_base + int'(ar_idx) * 32 +: 32];
        end
      end else begin
        next_rresp = `RESP_DECERR;
      end
    end
    next_awready = !next_aw_held;
    next_wready = !next_w_held;
    next_arready = !next_rvalid;
    next_backend_power = power & dev_mask;
    if (slot_type == `SLOT_SHARED) begin
      next_width_8bit = (eff_sel != 3'h0) && BUS_WIDTH_PRESET[eff_sel - 3'h1];
    end else begin
      next_width_8bit = ext_width_8;
    end
    next_int_pending = |(~int_sync & int_sel & int_mask);
    next_use_interrupt_cycle = (int_sel == 3'h0);
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_addr <= 12'h000;
      w_held <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      awready <= 1'b0;
      wready <= 1'b0;
      arready <= 1'b0;
      bvalid <= 1'b0;
      bresp <= `RESP_OKAY;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= `RESP_OKAY;
      power <= `POWER_RST;
      int_sel <= `INT_SEL_RST;
      clk_sel <= `CLK_SEL_RST;
      backend_power <= 7'h00;
      host_interface_supply <= 1'b0;
      width_8bit <= 1'b0;
      int_pending <= 1'b0;
      use_interrupt_cycle <= 1'b1;
    end else begin
      aw_held <= next_aw_held;
      aw_addr <= next_aw_addr;
      w_held <= next_w_held;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      awready <= next_awready;
      wready <= next_wready;
      arready <= next_arready;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      rvalid <= next_rvalid;
      rdata <= next_rdata;
      rresp <= next_rresp;
      power <= next_power;
      int_sel <= next_int_sel;
      clk_sel <= next_clk_sel;
      backend_power <= next_backend_power;
      host_interface_supply <= 1'b1;
      width_8bit <= next_width_8bit;
      int_pending <= next_int_pending;
      use_interrupt_cycle <= next_use_interrupt_cycle;
    end
  end

  // ****************************************************************
  // Interrupt input synchroniser
  // ****************************************************************
  // two-stage sync
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      int_meta <= 3'h7;
      int_sync <= 3'h7;
    end else begin
      int_meta <= int_n;
      int_sync <= int_meta;
    end
  end

  // ****************************************************************
  // Clock switch
  // ****************************************************************
  assign link.req_sel = eff_sel;
  assign link.req_div = sel_init_preset[`DIV_LSB +: 10];
  assign link.req_drive = sel_init_preset[`DRIVE_LSB +: 2];

  clock_switch u_clock_switch (
    .aclk(aclk),
    .aresetn(aresetn),
    .link(link.switcher)
  );

  assign dev_clk = link.dev_clk;
  assign clk_divider = link.div;
  assign drive_strength = link.drive;
  assign clk_switching = link.busy;

  logic unused_ok;
  assign unused_ok = ^{awprot, arprot, ar_ofs[11:4], ar_ofs[1:0], aw_addr[1:0],
                       w_strb[1:0], w_data[31], w_data[23], w_data[19],
                       w_data[15:0]};

endmodule : shared_bus_control

// ==== rtl/shared_bus_defs.svh ====
/*
  Offsets, field positions, reset values and codes of the shared bus control block.
  Assumes the includer uses the macros with the widths given here.
*/
// Summary of operation
// - Optional shared bus control word sits at byte offset 0E0h.
// - Bits 30..24 switch back-end power per device, bit 24 is device one.
// - Host interface supply is never switched by this word; it stays on.
// - Up to seven devices served; count equals the clock pin count field.
// - Bits 22..20 enable interrupt inputs A, B, C; all clear means interrupt cycle.
// - Enabling an unsupported interrupt input raises no interrupt, but it still clears the interrupt cycle flag.
// - Bits 18..16 pick the one running device clock; zero stops all.
// - Selecting an unimplemented clock output drives no clock.
// - Bits 14..8 give fixed per-device width, zero four lines, one eight.
// - Per-device widths apply only when slot type reports shared bus 10b.
// - Otherwise the extended width bit of host control one selects eight lines.
// - Bits 5..4 report interrupt inputs present: none, A, A-B, A-B-C.
// - Interrupt inputs are active low, asynchronous, wire-ORed and synchronised.
// - Bits 2..0 report clock output count; zero means no shared bus.
// - Old clock stops before new one starts, no overlap, no glitch.
// - Frequency and drive strength change only while all clocks are stopped.
// - One preset value set per device, the selected device's set is visible.
`ifndef SHARED_BUS_DEFS_SVH
`define SHARED_BUS_DEFS_SVH

// ****************************************************************
// Addresses
// ****************************************************************
`define CTRL_OFS 12'h0E0
`define PRESET_FIRST_OFS 12'h060
`define PRESET_LAST_OFS 12'h06C

// ****************************************************************
// Field positions
// ****************************************************************
`define POWER_LSB 24
`define INT_SEL_LSB 20
`define CLK_SEL_LSB 16
`define WIDTH_LSB 8
`define NUM_INT_LSB 4
`define NUM_CLK_LSB 0
`define DRIVE_LSB 14
`define DIV_LSB 0

// ****************************************************************
// Reset values and codes
// ****************************************************************
`define POWER_RST 7'h00
`define INT_SEL_RST 3'h0
`define CLK_SEL_RST 3'h0
`define SLOT_SHARED 2'h2
`define RESP_OKAY 2'h0
`define RESP_DECERR 2'h3
`define MAX_DEVICES 7
`define PRESETS_PER_DEVICE 8

`endif

// ==== rtl/shared_bus_pkg.sv ====
/*
  Types of the shared bus control block.
  Assumes nothing of its surroundings.
*/
package shared_bus_pkg;

  // ****************************************************************
  // Clock switch states, Gray coded along the run path
  // ****************************************************************
  typedef enum logic [1:0] {
    CLK_RUN = 2'h0,
    CLK_STOP = 2'h1,
    CLK_GAP = 2'h3,
    CLK_START = 2'h2
  } clk_state_e;

  typedef logic [2:0] dev_sel_t;

endpackage : shared_bus_pkg

// ==== rtl/clk_sel_if.sv ====
/*
  Link between the register bank and the clock switch.
  Assumes both ends run on one clock.
*/
`timescale 1ns/100ps
interface clk_sel_if;
  shared_bus_pkg::dev_sel_t req_sel;
  logic [9:0] req_div;
  logic [1:0] req_drive;
  logic [6:0] dev_clk;
  logic [9:0] div;
  logic [1:0] drive;
  logic busy;

  modport ctrl (output req_sel, output req_div, output req_drive,
                input dev_clk, input div, input drive, input busy);
  modport switcher (input req_sel, input req_div, input req_drive,
                    output dev_clk, output div, output drive, output busy);
endinterface : clk_sel_if

// ==== rtl/clock_switch.sv ====
/*
  Glitch-free device clock switch with divider.
  Assumes the requested selection is already limited to implemented outputs.
*/
`timescale 1ns/100ps
module clock_switch (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Link to register bank
  clk_sel_if.switcher link
);

  shared_bus_pkg::clk_state_e state, next_state;
  shared_bus_pkg::dev_sel_t cur_sel, next_cur_sel;
  logic [9:0] count, next_count;
  logic [9:0] div, next_div;
  logic [1:0] drive, next_drive;
  logic phase, next_phase;
  logic [6:0] dev_clk, next_dev_clk;
  logic busy, next_busy;
  logic toggle;

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    next_state = state;
    next_cur_sel = cur_sel;
    next_count = count;
    next_div = div;
    next_drive = drive;
    next_phase = phase;
    toggle = (count >= div) || (div == 10'h000);
    if ((state == shared_bus_pkg::CLK_RUN || state == shared_bus_pkg::CLK_STOP) && cur_sel != 3'h0) begin
      next_count = toggle ? 10'h000 : count + 10'h001;
      next_phase = toggle ? ~phase : phase;
    end
    case (state)
      shared_bus_pkg::CLK_RUN: begin
        if (link.req_sel != cur_sel) begin
          next_state = shared_bus_pkg::CLK_STOP;
        end
      end
      shared_bus_pkg::CLK_STOP: begin
        if (!phase) begin
          next_phase = 1'b0;
          next_cur_sel = 3'h0;
          next_state = shared_bus_pkg::CLK_GAP;
        end
      end
      shared_bus_pkg::CLK_GAP: begin
        next_div = link.req_div;
        next_drive = link.req_drive;
        next_count = 10'h000;
        next_state = shared_bus_pkg::CLK_START;
      end
      shared_bus_pkg::CLK_START: begin
        next_cur_sel = link.req_sel;
        next_state = shared_bus_pkg::CLK_RUN;
      end
      default: begin
        next_state = shared_bus_pkg::CLK_STOP;
      end
    endcase
    for (int i = 0; i < 7; i++) begin
      next_dev_clk[i] = next_phase && (next_cur_sel == 3'(i + 1));
    end
    next_busy = (next_state != shared_bus_pkg::CLK_RUN);
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= shared_bus_pkg::CLK_RUN;
      cur_sel <= 3'h0;
      count <= 10'h000;
      div <= 10'h000;
      drive <= 2'h0;
      phase <= 1'b0;
      dev_clk <= 7'h00;
      busy <= 1'b0;
    end else begin
      state <= next_state;
      cur_sel <= next_cur_sel;
      count <= next_count;
      div <= next_div;
      drive <= next_drive;
      phase <= next_phase;
      dev_clk <= next_dev_clk;
      busy <= next_busy;
    end
  end

  assign link.dev_clk = dev_clk;
  assign link.div = div;
  assign link.drive = drive;
  assign link.busy = busy;

endmodule : clock_switch

// ==== tb/bus_ctrl_props.sv ====
/*
  Port checker of the shared bus control block.
  Assumes it is bound to the top module and sees only its ports.
*/
`timescale 1ns/100ps
`include "shared_bus_defs.svh"
module bus_ctrl_props #(
  parameter logic [2:0] NUM_CLK_PINS = 3'h7,
  parameter logic [1:0] NUM_INT_PINS = 2'h3,
  parameter logic [6:0] BUS_WIDTH_PRESET = 7'h00
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Register bus
  input wire logic [11:0] awaddr,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic [11:0] araddr,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic rvalid,
  input wire logic rready,
  // Device side
  input wire logic [2:0] int_n,
  input wire logic [6:0] backend_power,
  input wire logic host_interface_supply,
  input wire logic [6:0] dev_clk,
  input wire logic [9:0] clk_divider,
  input wire logic [1:0] drive_strength,
  input wire logic int_pending,
  input wire logic use_interrupt_cycle
);
  // ****************************************
  // Properties
  // ****************************************
  localparam logic [6:0] CLK_MASK = 7'(127 >> (7 - NUM_CLK_PINS));
  localparam logic [2:0] INT_MASK = 3'(7 >> (3 - NUM_INT_PINS));
  localparam logic [6:0] WIDTH_SHOWN = BUS_WIDTH_PRESET & CLK_MASK;
  logic [11:0] last_ar;
  logic [11:0] next_last_ar;
  always_comb begin
    next_last_ar = (arvalid && arready) ? araddr : last_ar;
  end
  always_ff @(posedge aclk) begin
    last_ar <= next_last_ar;
  end
  default clocking @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  sequence s_on;
    dev_clk != 7'h00;
  endsequence
  sequence s_quiet;
    (int_n == 3'h7) [*3];
  endsequence
  chk_clk_onehot: assert property ($onehot0(dev_clk))
    else $error("two device clocks active");
  chk_no_overlap: assert property (s_on ##1 s_on |-> dev_clk == $past(dev_clk))
    else $error("clock moved without a stop gap");
  chk_gap_load: assert property ((!$stable(clk_divider) || !$stable(drive_strength)) |-> dev_clk == 7'h00)
    else $error("divider or drive changed while a clock ran");
  chk_supply_on: assert property ($past(aresetn) |-> host_interface_supply)
    else $error("host interface supply dropped");
  chk_power_mask: assert property ((backend_power & ~CLK_MASK) == 7'h00)
    else $error("power on an unserved device");
  chk_unimpl_clk: assert property ((dev_clk & ~CLK_MASK) == 7'h00)
    else $error("clock on an unimplemented output");
  chk_int_gate: assert property (int_pending |-> ((~$past(int_n, 3)) & INT_MASK) != 3'h0)
    else $error("interrupt without a supported low input");
  chk_int_quiet: assert property (s_quiet |=> !int_pending)
    else $error("interrupt while all inputs high");
  chk_ro_fields: assert property (rvalid && last_ar == `CTRL_OFS |-> (rdata & 32'h8088_80C8) == 32'h0
      && rdata[2:0] == NUM_CLK_PINS && rdata[5:4] == NUM_INT_PINS && rdata[14:8] == WIDTH_SHOWN)
    else $error("fixed or reserved field wrong");
  chk_int_cycle: assert property (awvalid && awready && wvalid && wready && awaddr == `CTRL_OFS && wstrb[2]
      |-> ##3 use_interrupt_cycle == ($past(wdata[22:20], 3) == 3'h0))
    else $error("interrupt cycle flag wrong");
  chk_rdata_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data not held");
endmodule : bus_ctrl_props
bind shared_bus_control bus_ctrl_props #(.NUM_CLK_PINS(NUM_CLK_PINS), .NUM_INT_PINS(NUM_INT_PINS),
  .BUS_WIDTH_PRESET(BUS_WIDTH_PRESET)) chk (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
  .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
  .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rvalid(rvalid), .rready(rready),
  .int_n(int_n), .backend_power(backend_power), .host_interface_supply(host_interface_supply),
  .dev_clk(dev_clk), .clk_divider(clk_divider), .drive_strength(drive_strength),
  .int_pending(int_pending), .use_interrupt_cycle(use_interrupt_cycle));

// ==== tb/card_bank.sv ====
/*
  Model of the embedded devices on the shared bus.
  Assumes wake requests come from the bench; counts clock rises per device.
*/
`timescale 1ns/100ps
module card_bank (
  // Clock
  input wire logic aclk,
  // Bus side
  input wire logic [6:0] dev_clk,
  input wire logic [2:0] wake,
  output logic [2:0] int_n,
  output int rises [7]
);
  int cnt [7] = '{default: 0};
  logic [6:0] last_clk = 7'h00;
  assign int_n = ~wake;
  assign rises = cnt;
  always @(posedge aclk) begin
    for (int i = 0; i < 7; i++) begin
      if (dev_clk[i] && !last_clk[i]) begin
        cnt[i] <= cnt[i] + 1;
      end
    end
    last_clk <= dev_clk;
  end
endmodule : card_bank

// ==== tb/test_shared_bus_control.sv ====
/*
  Self-checking bench of the shared bus control block.
  Assumes the checker is bound and the device model sits on the bus side.
*/
`timescale 1ns/100ps
module test_shared_bus_control;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, ext_width_8;
  logic awready, wready, bvalid, arready, rvalid, host_interface_supply;
  logic clk_switching, width_8bit, int_pending, use_interrupt_cycle;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [3:0] wstrb;
  logic [1:0] slot_type, bresp, rresp, drive_strength, resp;
  logic [2:0] wake, int_n;
  logic [6:0] backend_power, dev_clk;
  logic [9:0] clk_divider;
  int rises [7];
  int n_mismatch = 0;
  int compares = 0;

  shared_bus_control #(.NUM_CLK_PINS(3'h3), .NUM_INT_PINS(2'h2), .BUS_WIDTH_PRESET(7'h05),
    .PRESETS(896'h8001 << 128)) uut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(3'h0), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .slot_type(slot_type), .ext_width_8(ext_width_8), .int_n(int_n), .backend_power(backend_power),
    .host_interface_supply(host_interface_supply), .dev_clk(dev_clk), .clk_divider(clk_divider),
    .drive_strength(drive_strength), .clk_switching(clk_switching), .width_8bit(width_8bit),
    .int_pending(int_pending), .use_interrupt_cycle(use_interrupt_cycle));
  card_bank dev (.aclk(aclk), .dev_clk(dev_clk), .wake(wake), .int_n(int_n), .rises(rises));

  // ****************************************
  // Helpers
  // ****************************************
  task automatic give_verdict();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : give_verdict
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic cyc(input int k);
    repeat (k) @(posedge aclk);
  endtask : cyc
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    int n;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    resp = bresp;
    bready <= 1'b0;
    if (n == 50) begin
      n_mismatch++;
      give_verdict();
    end
  endtask : wr
  task automatic rd_reg(input logic [11:0] a);
    int n;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    rd = rdata;
    resp = rresp;
    rready <= 1'b0;
    if (n == 50) begin
      n_mismatch++;
      give_verdict();
    end
  endtask : rd_reg

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_fields();
    rd_reg(12'h0E0);
    check("ctrl", rd, 32'h0000_0523);
    check("supply", 32'(host_interface_supply), 32'h1);
    wr(12'h0E0, 32'hFFFF_FFFF, 4'hF);
    check("bresp", 32'(resp), 32'h0);
    rd_reg(12'h0E0);
    check("ctrl", rd, 32'h7F77_0523);
    check("power", 32'(backend_power), 32'h7);
    cyc(20);
    check("clk", 32'(dev_clk), 32'h0);
    check("rise7", 32'(rises[6]), 32'h0);
    wr(12'h0E0, 32'h0, 4'h4);
    rd_reg(12'h0E0);
    check("ctrl", rd, 32'h7F00_0523);
    wr(12'h0E0, 32'h0, 4'h8);
    cyc(2);
    check("power", 32'(backend_power), 32'h0);
    check("supply", 32'(host_interface_supply), 32'h1);
    wr(12'h0E4, 32'hFFFF_FFFF, 4'hF);
    check("bresp", 32'(resp), 32'h3);
    rd_reg(12'h0E4);
    check("rresp", 32'(resp), 32'h3);
    check("rdata", rd, 32'h0);
    rd_reg(12'h0E0);
    check("ctrl", rd, 32'h0000_0523);
    $display("test fields done");
  endtask : t_fields
  task automatic t_irq();
    check("icycle", 32'(use_interrupt_cycle), 32'h1);
    wr(12'h0E0, 32'h0070_0000, 4'h4);
    wake <= 3'h4;
    cyc(6);
    check("pend", 32'(int_pending), 32'h0);
    wake <= 3'h1;
    cyc(6);
    check("pend", 32'(int_pending), 32'h1);
    check("icycle", 32'(use_interrupt_cycle), 32'h0);
    wr(12'h0E0, 32'h0020_0000, 4'h4);
    cyc(4);
    check("pend", 32'(int_pending), 32'h0);
    wake <= 3'h3;
    cyc(6);
    check("pend", 32'(int_pending), 32'h1);
    wake <= 3'h0;
    wr(12'h0E0, 32'h0, 4'h4);
    cyc(4);
    check("pend", 32'(int_pending), 32'h0);
    check("icycle", 32'(use_interrupt_cycle), 32'h1);
    $display("test irq done");
  endtask : t_irq
  task automatic t_clock();
    int b0;
    int b1;
    wr(12'h0E0, 32'h0001_0000, 4'h4);
    cyc(40);
    b0 = rises[0];
    cyc(20);
    check("rise1", 32'(rises[0] - b0), 32'hA);
    check("rise2", 32'(rises[1]), 32'h0);
    slot_type <= 2'h2;
    cyc(3);
    check("w8", 32'(width_8bit), 32'h1);
    wr(12'h0E0, 32'h0002_0000, 4'h4);
    cyc(1);
    check("switching", 32'(clk_switching), 32'h1);
    cyc(40);
    b0 = rises[0];
    b1 = rises[1];
    cyc(40);
    check("rise2", 32'(rises[1] - b1), 32'hA);
    check("rise1", 32'(rises[0] - b0), 32'h0);
    check("div", 32'(clk_divider), 32'h1);
    check("drive", 32'(drive_strength), 32'h2);
    check("switching", 32'(clk_switching), 32'h0);
    rd_reg(12'h060);
    check("preset", rd, 32'h0000_8001);
    check("rresp", 32'(resp), 32'h0);
    wr(12'h060, 32'hFFFF_FFFF, 4'hF);
    check("bresp", 32'(resp), 32'h0);
    ext_width_8 <= 1'b1;
    cyc(3);
    check("w8", 32'(width_8bit), 32'h0);
    slot_type <= 2'h0;
    cyc(3);
    check("w8", 32'(width_8bit), 32'h1);
    ext_width_8 <= 1'b0;
    wr(12'h0E0, 32'h0, 4'h4);
    cyc(20);
    check("w8", 32'(width_8bit), 32'h0);
    check("clk", 32'(dev_clk), 32'h0);
    $display("test clock done");
  endtask : t_clock

  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, ext_width_8} = 7'h00;
    {awaddr, araddr, wdata, wstrb, slot_type, wake} = '0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    t_fields();
    t_irq();
    t_clock();
    give_verdict();
  end
endmodule : test_shared_bus_control
